// ---- include/ssg_pkg.sv ----
// constants, field layout and state type of the switching sequence generator
package ssg_pkg;

    localparam int unsigned NUM_CH = 24;
    localparam int unsigned NUM_OBJ = 5;
    localparam int unsigned ADDR_W = 12;

    // register byte offsets
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_CHSEL = 12'h004;
    localparam logic [11:0] OFF_STAT = 12'h008;

    // control register fields
    localparam int unsigned CTRL_TWO_CH_BIT = 0;
    localparam int unsigned CTRL_SCHEME_B_BIT = 1;
    localparam int unsigned CTRL_WRAP_BIT = 2;
    localparam int unsigned CTRL_PAT_LSB = 4;
    localparam int unsigned CTRL_CNT_LSB = 8;
    localparam int unsigned CTRL_RESTART_BIT = 12;

    // channel select fields
    localparam int unsigned CHSEL_A_LSB = 0;
    localparam int unsigned CHSEL_B_LSB = 8;

    // status fields
    localparam int unsigned STAT_IDX_LSB = 0;
    localparam int unsigned STAT_DIR_BIT = 8;
    localparam int unsigned STAT_OUT_LSB = 16;
    localparam int unsigned STAT_ACT_LSB = 24;

    // channel numbering: physical, virtual, logic, timer
    localparam logic [4:0] CH_PHYS_BASE = 5'h00;
    localparam logic [4:0] CH_VIRT_BASE = 5'h08;
    localparam logic [4:0] CH_LOGIC_BASE = 5'h10;
    localparam logic [4:0] CH_TIMER_BASE = 5'h14;

    // pattern codes
    localparam logic [2:0] PAT_BINARY = 3'h0;
    localparam logic [2:0] PAT_GRAY = 3'h1;
    localparam logic [2:0] PAT_QUEUE = 3'h2;
    localparam logic [2:0] PAT_PAUSE = 3'h3;
    localparam logic [2:0] PAT_FILL = 3'h4;

    localparam logic [2:0] CNT_MIN = 3'h2;
    localparam logic [2:0] CNT_MAX = 3'h5;

    // reset values
    localparam logic [2:0] RST_PAT = PAT_BINARY;
    localparam logic [2:0] RST_CNT = CNT_MIN;
    localparam logic [4:0] RST_SRC_A = 5'h00;
    localparam logic [4:0] RST_SRC_B = 5'h01;

    typedef struct packed {
        logic [4:0] idx;
        logic dir_fwd;
        logic [4:0] obj_out;
        logic [4:0] obj_act;
        logic two_ch;
        logic scheme_b;
        logic wrap;
        logic [2:0] pat;
        logic [2:0] cnt;
        logic [4:0] src_a;
        logic [4:0] src_b;
        logic sw_prev;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ssg_state_t;

    localparam ssg_state_t ST_RESET = '{
        idx: 5'h00, dir_fwd: 1'b1, obj_out: 5'h00, obj_act: 5'h03,
        two_ch: 1'b0, scheme_b: 1'b0, wrap: 1'b0, pat: RST_PAT, cnt: RST_CNT,
        src_a: RST_SRC_A, src_b: RST_SRC_B, sw_prev: 1'b0,
        pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000};

endpackage

// ---- rtl/ssg_top.sv ----
// switching sequence generator with apb configuration port
`timescale 1ns/1ps
`default_nettype none

module ssg_top (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ssg_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [ssg_pkg::NUM_CH-1:0] ch_short,
    input wire logic [ssg_pkg::NUM_CH-1:0] ch_long,
    input wire logic [ssg_pkg::NUM_CH-1:0] ch_state,
    output logic [ssg_pkg::NUM_OBJ-1:0] seq_out,
    output logic [ssg_pkg::NUM_OBJ-1:0] obj_active,
    output logic step_dir_fwd
);
    import ssg_pkg::*;

    ssg_state_t q;
    ssg_state_t d;

    // channel numbers past the last channel select nothing
    function automatic logic sel_ch(input logic [NUM_CH-1:0] vec, input logic [4:0] ch);
        sel_ch = (ch < 5'(NUM_CH)) ? vec[ch] : 1'b0;
    endfunction

    function automatic logic [4:0] obj_count(input logic [2:0] cnt);
        if (cnt < CNT_MIN) begin
            obj_count = {2'b00, CNT_MIN};
        end else if (cnt > CNT_MAX) begin
            obj_count = {2'b00, CNT_MAX};
        end else begin
            obj_count = {2'b00, cnt};
        end
    endfunction

    function automatic logic [4:0] obj_mask(input logic [2:0] cnt);
        obj_mask = 5'((6'h01 << obj_count(cnt)) - 6'h01);
    endfunction

    function automatic logic [4:0] last_idx(input logic [2:0] pat, input logic [2:0] cnt);
        logic [4:0] n;
        n = obj_count(cnt);
        unique case (pat)
            PAT_BINARY, PAT_GRAY: last_idx = 5'((6'h01 << n) - 6'h01);
            PAT_PAUSE: last_idx = 5'((n << 1) - 5'h01);
            default: last_idx = n;
        endcase
    endfunction

    function automatic logic [4:0] pattern_out(input logic [2:0] pat, input logic [4:0] idx);
        unique case (pat)
            PAT_BINARY: pattern_out = idx;
            PAT_GRAY: pattern_out = idx ^ (idx >> 1);
            PAT_QUEUE: pattern_out = (idx == 5'h00) ? 5'h00 : 5'(5'h01 << (idx - 5'h01));
            PAT_PAUSE: pattern_out = idx[0] ? 5'(5'h01 << (idx >> 1)) : 5'h00;
            PAT_FILL: pattern_out = 5'((5'h01 << idx) - 5'h01);
            default: pattern_out = 5'h00;
        endcase
    endfunction

    function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
        reg_mapped = (a == OFF_CTRL) || (a == OFF_CHSEL) || (a == OFF_STAT);
    endfunction

    function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        strb_merge = (old & ~m) | (wd & m);
    endfunction

    logic [31:0] ctrl_word;
    logic [31:0] chsel_word;
    logic [31:0] stat_word;
    logic apb_wr;
    logic wr_ctrl;
    logic wr_chsel;
    logic [31:0] ctrl_new;
    logic [31:0] chsel_new;
    logic a_short;
    logic a_long;
    logic b_short;
    logic sw_now;
    logic dir_level;
    logic sw_fall;
    logic fwd_req;
    logic bwd_req;
    logic dir_toggle;
    logic step_fwd;
    logic step_bwd;
    logic restart;
    logic [4:0] last;

    always_comb begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[CTRL_TWO_CH_BIT] = q.two_ch;
        ctrl_word[CTRL_SCHEME_B_BIT] = q.scheme_b;
        ctrl_word[CTRL_WRAP_BIT] = q.wrap;
        ctrl_word[CTRL_PAT_LSB +: 3] = q.pat;
        ctrl_word[CTRL_CNT_LSB +: 3] = q.cnt;
        chsel_word = 32'h0000_0000;
        chsel_word[CHSEL_A_LSB +: 5] = q.src_a;
        chsel_word[CHSEL_B_LSB +: 5] = q.src_b;
        stat_word = 32'h0000_0000;
        stat_word[STAT_IDX_LSB +: 5] = q.idx;
        stat_word[STAT_DIR_BIT] = q.dir_fwd;
        stat_word[STAT_OUT_LSB +: 5] = q.obj_out;
        stat_word[STAT_ACT_LSB +: 5] = q.obj_act;
    end

    // a write lands on the access edge only; errored accesses change nothing
    assign apb_wr = psel && penable && q.pready && pwrite && !q.pslverr;
    assign wr_ctrl = apb_wr && (paddr == OFF_CTRL);
    assign wr_chsel = apb_wr && (paddr == OFF_CHSEL);
    assign ctrl_new = strb_merge(ctrl_word, pwdata, pstrb);
    assign chsel_new = strb_merge(chsel_word, pwdata, pstrb);
    // restart is a self-clearing command bit, so only its own byte lane counts
    assign restart = wr_ctrl && pstrb[CTRL_RESTART_BIT / 8] && pwdata[CTRL_RESTART_BIT];

    // only the selected channels are looked at
    assign a_short = sel_ch(ch_short, q.src_a);
    assign a_long = sel_ch(ch_long, q.src_a);
    assign b_short = sel_ch(ch_short, q.src_b);
    assign sw_now = sel_ch(ch_state, q.src_a);
    assign dir_level = sel_ch(ch_state, q.src_b);
    // edge is seen relative to last cycle's level of the channel chosen in that cycle
    assign sw_fall = q.sw_prev && !sw_now;

    always_comb begin
        fwd_req = 1'b0;
        bwd_req = 1'b0;
        dir_toggle = 1'b0;
        if (!q.two_ch) begin
            fwd_req = a_short && q.dir_fwd;
            bwd_req = a_short && !q.dir_fwd;
            dir_toggle = a_long;
        end else if (!q.scheme_b) begin
            fwd_req = a_short;
            bwd_req = b_short;
        end else begin
            fwd_req = sw_fall && dir_level;
            bwd_req = sw_fall && !dir_level;
        end
    end

    // both requests at once with both channels pressed together or one channel in both roles: do nothing
    assign step_fwd = fwd_req && !bwd_req;
    assign step_bwd = bwd_req && !fwd_req;
    assign last = last_idx(q.pat, q.cnt);

    always_comb begin
        d = q;
        d.sw_prev = sw_now;
        // zero wait states: answer prepared in setup, shown in access
        d.pready = psel && !penable;
        d.pslverr = 1'b0;
        d.prdata = 32'h0000_0000;
        if (psel && !penable) begin
            d.pslverr = !reg_mapped(paddr);
            if (!pwrite) begin
                if (paddr == OFF_CTRL) begin
                    d.prdata = ctrl_word;
                end else if (paddr == OFF_CHSEL) begin
                    d.prdata = chsel_word;
                end else if (paddr == OFF_STAT) begin
                    d.prdata = stat_word;
                end
            end
        end

        if (step_fwd) begin
            if (q.idx >= last) begin
                d.idx = q.wrap ? 5'h00 : q.idx;
            end else begin
                d.idx = q.idx + 5'h01;
            end
        end else if (step_bwd) begin
            if (q.idx > last) begin
                d.idx = last;
            end else if (q.idx != 5'h00) begin
                d.idx = q.idx - 5'h01;
            end
        end
        if (dir_toggle) begin
            d.dir_fwd = !q.dir_fwd;
        end

        if (wr_ctrl) begin
            d.two_ch = ctrl_new[CTRL_TWO_CH_BIT];
            d.scheme_b = ctrl_new[CTRL_SCHEME_B_BIT];
            d.wrap = ctrl_new[CTRL_WRAP_BIT];
            d.pat = ctrl_new[CTRL_PAT_LSB +: 3];
            d.cnt = ctrl_new[CTRL_CNT_LSB +: 3];
        end
        if (wr_chsel) begin
            d.src_a = chsel_new[CHSEL_A_LSB +: 5];
            d.src_b = chsel_new[CHSEL_B_LSB +: 5];
        end
        // restart wins over any step taken in the same cycle
        if (restart) begin
            d.idx = 5'h00;
            d.dir_fwd = 1'b1;
        end

        d.obj_act = obj_mask(d.cnt);
        // every pattern maps index zero to all off, so restart clears outputs
        d.obj_out = pattern_out(d.pat, d.idx) & obj_mask(d.cnt);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            q <= ST_RESET;
        end else begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign seq_out = q.obj_out;
    assign obj_active = q.obj_act;
    assign step_dir_fwd = q.dir_fwd;

    // checks

    sequence s_fwd_at_end;
        step_fwd && !restart && !wr_ctrl && (q.idx >= last);
    endsequence

    sequence s_fwd_mid;
        step_fwd && !restart && !wr_ctrl && (q.idx < last);
    endsequence

    a_queue_onehot: assert property (@(posedge ref_clk) disable iff (rst)
        (q.pat == PAT_QUEUE) && (q.idx != 5'h00) && (q.idx <= obj_count(q.cnt))
        |-> $onehot(q.obj_out))
        else $error("queue step does not light exactly one object");

    a_pause_gap: assert property (@(posedge ref_clk) disable iff (rst)
        (q.pat == PAT_PAUSE) && !q.idx[0] |-> (q.obj_out == 5'h00))
        else $error("pause step not all off");

    // odd pause steps light one object, so a gap cannot hide a wrong lit step
    a_pause_lit: assert property (@(posedge ref_clk) disable iff (rst)
        (q.pat == PAT_PAUSE) && q.idx[0] && (q.idx <= last) |-> $onehot(q.obj_out))
        else $error("pause lit step not a single object");

    a_fill_shape: assert property (@(posedge ref_clk) disable iff (rst)
        (q.pat == PAT_FILL) && (q.idx <= obj_count(q.cnt))
        |-> ($countones(q.obj_out) == int'(q.idx)) && (((q.obj_out + 5'h01) & q.obj_out) == 5'h00))
        else $error("fill step has wrong shape");

    a_short_step: assert property (@(posedge ref_clk) disable iff (rst)
        !q.two_ch && a_short && q.dir_fwd ##0 s_fwd_mid |=> (q.idx == $past(q.idx) + 5'h01))
        else $error("short press did not advance one step");

    a_long_dir: assert property (@(posedge ref_clk) disable iff (rst)
        !q.two_ch && a_long && !a_short && !restart && !wr_ctrl
        |=> (q.dir_fwd != $past(q.dir_fwd)) && $stable(q.obj_out))
        else $error("long press did not just flip direction");

    a_scheme_a_back: assert property (@(posedge ref_clk) disable iff (rst)
        q.two_ch && !q.scheme_b && b_short && !a_short && !restart && !wr_ctrl
        && (q.idx != 5'h00) && (q.idx <= last) |=> (q.idx == $past(q.idx) - 5'h01))
        else $error("previous-step press did not step back");

    a_scheme_a_fwd: assert property (@(posedge ref_clk) disable iff (rst)
        q.two_ch && !q.scheme_b && a_short ##0 s_fwd_mid |=> (q.idx == $past(q.idx) + 5'h01))
        else $error("next-step press did not step forward");

    a_scheme_b_edge: assert property (@(posedge ref_clk) disable iff (rst)
        q.two_ch && q.scheme_b && !restart && !wr_ctrl && !(q.sw_prev && !sw_now)
        |=> $stable(q.idx))
        else $error("step taken without a falling edge");

    a_scheme_b_back: assert property (@(posedge ref_clk) disable iff (rst)
        q.two_ch && q.scheme_b && sw_fall && !dir_level && !restart && !wr_ctrl
        && (q.idx != 5'h00) && (q.idx <= last) |=> (q.idx == $past(q.idx) - 5'h01))
        else $error("falling edge with direction low did not step back");

    a_stop_end: assert property (@(posedge ref_clk) disable iff (rst)
        !q.wrap ##0 s_fwd_at_end |=> $stable(q.idx) ##1 1'b1)
        else $error("forward past last step without wrap");

    // the end stop must not lock the index: backing off the last step works
    a_stop_back: assert property (@(posedge ref_clk) disable iff (rst)
        !q.wrap && step_bwd && !restart && !wr_ctrl && (q.idx == last) && (q.idx != 5'h00)
        |=> (q.idx == $past(q.idx) - 5'h01))
        else $error("backward step refused at last step");

    a_wrap_end: assert property (@(posedge ref_clk) disable iff (rst)
        q.wrap ##0 s_fwd_at_end |=> (q.idx == 5'h00) && (q.obj_out == 5'h00))
        else $error("wrap did not clear outputs");

    // a restart jumps to index zero and is not a gray step
    a_gray_one: assert property (@(posedge ref_clk) disable iff (rst)
        (q.pat == PAT_GRAY) && $stable(q.pat) && $stable(q.cnt) && $changed(q.idx)
        && !$past(restart)
        |-> ($countones(q.obj_out ^ $past(q.obj_out)) == 1))
        else $error("gray step changed more than one object");

    a_binary_value: assert property (@(posedge ref_clk) disable iff (rst)
        (q.pat == PAT_BINARY) |-> (q.obj_out == (q.idx & q.obj_act)))
        else $error("binary output differs from index");

    a_count_mask: assert property (@(posedge ref_clk) disable iff (rst)
        (q.obj_out & ~q.obj_act) == 5'h00)
        else $error("object beyond configured count driven");

    a_restart_clear: assert property (@(posedge ref_clk) disable iff (rst)
        restart |=> (q.obj_out == 5'h00) && (q.idx == 5'h00) && q.dir_fwd)
        else $error("restart did not clear the sequence");

    a_apb_answer: assert property (@(posedge ref_clk) disable iff (rst)
        psel && !penable |=> pready ##1 !pready)
        else $error("apb answer not one access cycle");

endmodule // ssg_top

`default_nettype wire

// ---- tb/ssg_chan_model.sv ----
// channel event source model for the sequence generator's control inputs
`timescale 1ns/1ps
`default_nettype none

module ssg_chan_model (
    input wire logic clk,
    output logic [ssg_pkg::NUM_CH-1:0] ch_short,
    output logic [ssg_pkg::NUM_CH-1:0] ch_long,
    output logic [ssg_pkg::NUM_CH-1:0] ch_state
);
    import ssg_pkg::*;

    initial begin
        ch_short = '0;
        ch_long = '0;
        ch_state = '0;
    end

    // press events last one cycle, as the channel front end emits them
    task automatic short_press(input int c);
        @(posedge clk);
        ch_short[c] <= 1'b1;
        @(posedge clk);
        ch_short[c] <= 1'b0;
    endtask

    task automatic long_press(input int c);
        @(posedge clk);
        ch_long[c] <= 1'b1;
        @(posedge clk);
        ch_long[c] <= 1'b0;
    endtask

    task automatic set_level(input int c, input logic v);
        @(posedge clk);
        ch_state[c] <= v;
    endtask
endmodule // ssg_chan_model

`default_nettype wire

// ---- tb/switching_sequence_generator_test.sv ----
// self-checking bench for the switching sequence generator
`timescale 1ns/1ps
`default_nettype none

module switching_sequence_generator_test;
    import ssg_pkg::*;

    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [NUM_CH-1:0] ch_short;
    logic [NUM_CH-1:0] ch_long;
    logic [NUM_CH-1:0] ch_state;
    logic [NUM_OBJ-1:0] seq_out;
    logic [NUM_OBJ-1:0] obj_active;
    logic step_dir_fwd;
    int n_fail = 0;
    int checks = 0;

    always #4 ref_clk = ~ref_clk;

    ssg_top uut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ch_short(ch_short), .ch_long(ch_long),
        .ch_state(ch_state), .seq_out(seq_out), .obj_active(obj_active),
        .step_dir_fwd(step_dir_fwd));

    ssg_chan_model chm (.clk(ref_clk), .ch_short(ch_short), .ch_long(ch_long),
        .ch_state(ch_state));

    task automatic results();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // one apb transfer; the slave's answer time is not assumed
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hf;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_fail++;
            results();
        end else begin
            r = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    // pattern, count, wrap, two-channel, scheme b; restart bit always set
    task automatic cfg(input int p, input int n, input bit wr_en, input bit two,
            input bit sb);
        wr(OFF_CTRL, 32'h1000 | (n << 8) | (p << 4) | (wr_en << 2) | (sb << 1) | two);
    endtask

    function automatic logic [4:0] pat_val(input int p, input int n, input int i);
        int v;
        case (p)
            0: v = i;
            1: v = i ^ (i >> 1);
            2: v = (i == 0) ? 0 : 1 << (i - 1);
            3: v = (i % 2) ? 1 << ((i - 1) / 2) : 0;
            default: v = (1 << i) - 1;
        endcase
        return 5'(v & ((1 << n) - 1));
    endfunction

    task automatic press(input int c, input logic [4:0] exp);
        chm.short_press(c);
        @(negedge ref_clk);
        chk({27'h0, seq_out}, {27'h0, exp}, "step output");
    endtask

    task automatic fall_step(input logic [4:0] exp);
        chm.set_level(20, 1'b1);
        chm.set_level(20, 1'b0);
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk({27'h0, seq_out}, {27'h0, exp}, "falling edge step");
    endtask

    task automatic t_reset();
        logic [31:0] r;
        logic e;
        @(negedge ref_clk);
        chk({27'h0, seq_out}, 32'h0, "reset outputs");
        chk({26'h0, obj_active, step_dir_fwd}, 32'h7, "reset mask and dir");
        apb(1'b0, OFF_CTRL, 32'h0, r, e);
        chk(r, 32'h0000_0200, "ctrl reset");
        apb(1'b0, OFF_CHSEL, 32'h0, r, e);
        chk(r, 32'h0000_0100, "chsel reset");
        apb(1'b0, 12'h00c, 32'h0, r, e);
        chk({r[30:0], e}, 32'h1, "unmapped read");
    endtask

    task automatic t_patterns();
        int l;
        for (int p = 0; p < 5; p++) begin
            for (int n = 2; n < 6; n++) begin
                cfg(p, n, 1'b0, 1'b0, 1'b0);
                l = (p < 2) ? (1 << n) - 1 : (p == 3) ? 2 * n - 1 : n;
                @(negedge ref_clk);
                chk({27'h0, obj_active}, 32'((1 << n) - 1), "object mask");
                for (int i = 1; i <= l; i++) begin
                    press(0, pat_val(p, n, i));
                end
                press(0, pat_val(p, n, l));
                chm.long_press(0);
                @(negedge ref_clk);
                chk({26'h0, seq_out, step_dir_fwd}, {26'h0, pat_val(p, n, l), 1'b0},
                    "long press");
                press(0, pat_val(p, n, l - 1));
            end
        end
    endtask

    task automatic t_scheme_a();
        wr(OFF_CHSEL, 32'h0000_0c05);
        cfg(0, 2, 1'b0, 1'b1, 1'b0);
        press(12, 5'h00);
        press(5, 5'h01);
        press(7, 5'h01);
        press(5, 5'h02);
        press(12, 5'h01);
    endtask

    task automatic t_scheme_b();
        wr(OFF_CHSEL, 32'h0000_1014);
        cfg(0, 2, 1'b0, 1'b1, 1'b1);
        chm.set_level(16, 1'b1);
        fall_step(5'h01);
        fall_step(5'h02);
        chm.set_level(16, 1'b0);
        fall_step(5'h01);
        press(20, 5'h01);
    endtask

    task automatic t_wrap_restart();
        wr(OFF_CHSEL, 32'h0000_0100);
        cfg(2, 2, 1'b1, 1'b0, 1'b0);
        press(0, 5'h01);
        press(0, 5'h02);
        press(0, 5'h00);
        press(0, 5'h01);
        chm.long_press(0);
        cfg(2, 2, 1'b1, 1'b0, 1'b0);
        @(negedge ref_clk);
        chk({26'h0, seq_out, step_dir_fwd}, 32'h1, "restart");
        press(0, 5'h01);
    endtask

    // gray wrap, an unused pattern code, count clamping and the status word
    task automatic t_codes();
        logic [31:0] r;
        logic e;
        cfg(1, 2, 1'b1, 1'b0, 1'b0);
        press(0, 5'h01);
        press(0, 5'h03);
        press(0, 5'h02);
        press(0, 5'h00);
        cfg(5, 7, 1'b0, 1'b0, 1'b0);
        @(negedge ref_clk);
        chk({27'h0, obj_active}, 32'h1f, "count above five");
        press(0, 5'h00);
        apb(1'b0, OFF_CTRL, 32'h0, r, e);
        chk(r, 32'h0000_0750, "raw count readback");
        cfg(4, 1, 1'b0, 1'b0, 1'b0);
        @(negedge ref_clk);
        chk({27'h0, obj_active}, 32'h3, "count below two");
        press(0, 5'h01);
        press(0, 5'h03);
        press(0, 5'h03);
        apb(1'b0, OFF_STAT, 32'h0, r, e);
        chk(r, 32'h0303_0102, "status word");
        chk({31'h0, e}, 32'h0, "status no error");
    endtask

    // a hang anywhere ends the run through the same report
    initial begin
        repeat (100000) @(posedge ref_clk);
        n_fail++;
        results();
    end

    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_patterns();
        t_scheme_a();
        t_scheme_b();
        t_wrap_restart();
        t_codes();
        results();
    end
endmodule // switching_sequence_generator_test

`default_nettype wire
